// ==== inc/dpscd_pkg.sv ====
// Contract
// - Step mode: each serial clock with data high moves wiper one step up.
// - Step mode: each serial clock with data low moves wiper one step down.
// - Any mix of up and down steps may follow within one frame.
// - Instruction byte: opcode, slot high, slot low, zero bit, pot select.
// - Opcode 1001 returns selected wiper position, MSB first, as third byte.
// - Opcode 1010 loads third byte into selected wiper position register.
// - Opcode 1011 returns selected stored position register, MSB first.
// - Opcode 1100 writes third byte to stored slot; starts at frame end.
// - Opcode 1101 copies selected stored slot into that pot's wiper register.
// - Opcode 1110 copies wiper into selected stored slot, nonvolatile.
// - Opcode 0001 copies chosen slot of every pot into its wiper at once.
// - Opcode 1000 copies both wipers into chosen slots, nonvolatile.
// - Opcode 0010 enables stepping of the selected wiper until frame end.
// - Frame executes only when the address bits match the address pins.
// - Data sampled on rising serial clock; chip select stays low all command.
// - Stored register writes finish within 10 ms; busy flag set meanwhile.
`default_nettype none
package dpscd_pkg;
  // Timing
  localparam int CLOCK_KHZ = 40000;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLOCK_KHZ;
  // Opcodes
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_STORED = 4'hb;
  localparam logic [3:0] OP_WR_STORED = 4'hc;
  localparam logic [3:0] OP_XFR_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_XFR_TO_STORED = 4'he;
  localparam logic [3:0] OP_GLB_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GLB_TO_STORED = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  // Instruction and identification byte fields
  localparam int FLD_OP_MSB = 7;
  localparam int FLD_OP_LSB = 4;
  localparam int FLD_SLOT_MSB = 3;
  localparam int FLD_SLOT_LSB = 2;
  localparam int FLD_ZERO = 1;
  localparam int FLD_POT = 0;
  localparam int FLD_ADDR_MSB = 1;
  localparam logic [1:0] ADDR_UPPER = 2'h0;
  // Bit counter marks
  localparam logic [4:0] BIT_ID_LAST = 5'h07;
  localparam logic [4:0] BIT_INSTR_LAST = 5'h0f;
  localparam logic [4:0] BIT_DATA_LAST = 5'h17;
  localparam logic [4:0] BIT_DONE = 5'h18;
  // Position values
  localparam logic [7:0] POS_MAX = 8'hff;
  localparam logic [7:0] POS_MIN = 8'h00;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] STORED_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ID = 3'h1,
    ST_INSTR = 3'h3,
    ST_DATA = 3'h2,
    ST_SKIP = 3'h6
  } dpscd_state_t;

  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
    logic [1:0] addr;
  } dpscd_pins_t;

  // Pin levels at rest; matching them avoids a false edge after reset
  localparam dpscd_pins_t PINS_IDLE = '{sck: 1'h0, cs_b: 1'h1, si: 1'h0,
                                        addr: 2'h0};
endpackage
`default_nettype wire

// ==== verilog/dpscd_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
module dpscd_decoder #(
  parameter logic [3:0] P_DEVICE_TYPE = 4'h9, // Arbitrary value
  parameter int P_NV_WRITE_CYCLES = dpscd_pkg::NV_WRITE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_si,
  input wire logic i_chip_address_bit_one,
  input wire logic i_chip_address_bit_zero,
  output logic o_so,
  output logic o_so_oe_b,
  output logic o_wip,
  output logic [7:0] o_wiper_pos_0,
  output logic [7:0] o_wiper_pos_1
);
  dpscd_pkg::dpscd_pins_t raw, syn1, syn2, syn3, filt, filt_q;
  dpscd_pkg::dpscd_state_t state;
  logic [4:0] cnt;
  logic [7:0] shreg, instr, data, tx, nbyte, rd_value;
  logic data_ok, reading, sck_rise, sck_fall, cs_fall, cs_rise, exec, nv_start;
  logic [7:0] wiper [2];
  logic [7:0] stored [8];
  logic [18:0] timer;
  logic [3:0] op;
  logic [1:0] slot;
  logic pot;

  // Opcode and field check of a fresh instruction byte
  function automatic logic instr_valid(input logic [7:0] b);
    logic [3:0] o;
    logic fixed_ok;
    o = b[dpscd_pkg::FLD_OP_MSB:dpscd_pkg::FLD_OP_LSB];
    fixed_ok = !b[dpscd_pkg::FLD_ZERO];
    case (o)
      dpscd_pkg::OP_RD_WIPER, dpscd_pkg::OP_WR_WIPER, dpscd_pkg::OP_STEP:
        instr_valid = fixed_ok && (b[3:2] == 2'h0);
      dpscd_pkg::OP_RD_STORED, dpscd_pkg::OP_WR_STORED,
      dpscd_pkg::OP_XFR_TO_WIPER, dpscd_pkg::OP_XFR_TO_STORED:
        instr_valid = fixed_ok;
      dpscd_pkg::OP_GLB_TO_WIPER, dpscd_pkg::OP_GLB_TO_STORED:
        instr_valid = fixed_ok && !b[dpscd_pkg::FLD_POT];
      default: instr_valid = 1'b0;
    endcase
  endfunction

  // Ops that start a nonvolatile write cycle
  function automatic logic is_nv(input logic [3:0] o);
    is_nv = (o == dpscd_pkg::OP_WR_STORED) ||
            (o == dpscd_pkg::OP_XFR_TO_STORED) ||
            (o == dpscd_pkg::OP_GLB_TO_STORED);
  endfunction

  // Field views and edge strobes
  assign raw = {i_sck, i_cs_b, i_si, i_chip_address_bit_one,
                i_chip_address_bit_zero};
  assign op = instr[dpscd_pkg::FLD_OP_MSB:dpscd_pkg::FLD_OP_LSB];
  assign slot = instr[dpscd_pkg::FLD_SLOT_MSB:dpscd_pkg::FLD_SLOT_LSB];
  assign pot = instr[dpscd_pkg::FLD_POT];
  assign nbyte = {shreg[6:0], filt.si};
  assign sck_rise = filt.sck && !filt_q.sck;
  assign sck_fall = !filt.sck && filt_q.sck;
  assign cs_fall = !filt.cs_b && filt_q.cs_b;
  assign cs_rise = filt.cs_b && !filt_q.cs_b;
  assign exec = cs_rise && (state == dpscd_pkg::ST_DATA);
  assign nv_start = exec && is_nv(op) && (timer == 19'h0_0000) &&
                    (data_ok || (op != dpscd_pkg::OP_WR_STORED));
  assign rd_value = (nbyte[7:4] == dpscd_pkg::OP_RD_WIPER) ?
                    wiper[nbyte[0]] : stored[{nbyte[0], nbyte[3:2]}];
  assign o_wiper_pos_0 = wiper[0];
  assign o_wiper_pos_1 = wiper[1];

  // Pin synchroniser; a level counts once the second and third stages agree
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      syn1 <= dpscd_pkg::PINS_IDLE;
      syn2 <= dpscd_pkg::PINS_IDLE;
      syn3 <= dpscd_pkg::PINS_IDLE;
      filt <= dpscd_pkg::PINS_IDLE;
      filt_q <= dpscd_pkg::PINS_IDLE;
    end else begin
      syn1 <= raw;
      syn2 <= syn1;
      syn3 <= syn2;
      // Agreeing stages give the new level, either way; else hold
      filt <= (syn2 & ~(syn2 ^ syn3)) | (filt & (syn2 ^ syn3));
      filt_q <= filt;
    end
  end

  // Frame sequencer: identification, instruction, then data or steps
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state <= dpscd_pkg::ST_IDLE;
      cnt <= 5'h00;
      shreg <= 8'h00;
      instr <= 8'h00;
      data <= 8'h00;
      data_ok <= 1'b0;
    end else if (cs_fall) begin
      state <= dpscd_pkg::ST_ID;
      cnt <= 5'h00;
      data_ok <= 1'b0;
    end else if (cs_rise) begin
      state <= dpscd_pkg::ST_IDLE;
    end else if (sck_rise) begin
      shreg <= nbyte;
      if (cnt != dpscd_pkg::BIT_DONE) begin
        cnt <= cnt + 5'h01;
      end
      case (state)
        dpscd_pkg::ST_ID: begin
          if (cnt == dpscd_pkg::BIT_ID_LAST) begin
            // Mismatch parks the frame so nothing else happens
            if (nbyte[7:4] == P_DEVICE_TYPE &&
                nbyte[3:2] == dpscd_pkg::ADDR_UPPER &&
                nbyte[dpscd_pkg::FLD_ADDR_MSB:0] == filt.addr) begin
              state <= dpscd_pkg::ST_INSTR;
            end else begin
              state <= dpscd_pkg::ST_SKIP;
            end
          end
        end
        dpscd_pkg::ST_INSTR: begin
          if (cnt == dpscd_pkg::BIT_INSTR_LAST) begin
            instr <= nbyte;
            state <= instr_valid(nbyte) ? dpscd_pkg::ST_DATA :
                     dpscd_pkg::ST_SKIP;
          end
        end
        dpscd_pkg::ST_DATA: begin
          if (cnt == dpscd_pkg::BIT_DATA_LAST) begin
            data <= nbyte;
            data_ok <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Wiper and stored position registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      for (int p = 0; p < 2; p++) begin
        wiper[p] <= dpscd_pkg::WIPER_RESET;
      end
      for (int s = 0; s < 8; s++) begin
        stored[s] <= dpscd_pkg::STORED_RESET;
      end
    end else begin
      // Steps apply at once; a frame may mix any number of both kinds
      if (sck_rise && !cs_rise && state == dpscd_pkg::ST_DATA) begin
        if (op == dpscd_pkg::OP_STEP) begin
          if (filt.si && wiper[pot] != dpscd_pkg::POS_MAX) begin
            wiper[pot] <= wiper[pot] + 8'h01;
          end else if (!filt.si && wiper[pot] != dpscd_pkg::POS_MIN) begin
            wiper[pot] <= wiper[pot] - 8'h01;
          end
        end else if (op == dpscd_pkg::OP_WR_WIPER &&
                     cnt == dpscd_pkg::BIT_DATA_LAST) begin
          wiper[pot] <= nbyte;
        end
      end
      // Transfers commit only on a complete frame's chip select rise
      if (exec) begin
        case (op)
          dpscd_pkg::OP_WR_STORED: begin
            if (nv_start) begin
              stored[{pot, slot}] <= data;
            end
          end
          dpscd_pkg::OP_XFR_TO_WIPER: begin
            wiper[pot] <= stored[{pot, slot}];
          end
          dpscd_pkg::OP_XFR_TO_STORED: begin
            if (nv_start) begin
              stored[{pot, slot}] <= wiper[pot];
            end
          end
          dpscd_pkg::OP_GLB_TO_WIPER: begin
            wiper[0] <= stored[{1'b0, slot}];
            wiper[1] <= stored[{1'b1, slot}];
          end
          dpscd_pkg::OP_GLB_TO_STORED: begin
            if (nv_start) begin
              stored[{1'b0, slot}] <= wiper[0];
              stored[{1'b1, slot}] <= wiper[1];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Nonvolatile write timer; a write asked for while busy is dropped
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      timer <= 19'h0_0000;
      o_wip <= 1'b0;
    end else begin
      if (nv_start) begin
        timer <= 19'(P_NV_WRITE_CYCLES);
      end else if (timer != 19'h0_0000) begin
        timer <= timer - 19'h0_0001;
      end
      o_wip <= nv_start || (timer > 19'h0_0001);
    end
  end

  // Serial output, launched on falling clock; the host samples late in the following high phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      tx <= 8'h00;
      o_so <= 1'b0;
      o_so_oe_b <= 1'b1;
      reading <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      o_so_oe_b <= 1'b1;
      reading <= 1'b0;
    end else begin
      if (sck_rise && state == dpscd_pkg::ST_INSTR &&
          cnt == dpscd_pkg::BIT_INSTR_LAST && instr_valid(nbyte) &&
          (nbyte[7:4] == dpscd_pkg::OP_RD_WIPER ||
           nbyte[7:4] == dpscd_pkg::OP_RD_STORED)) begin
        tx <= rd_value;
        reading <= 1'b1;
      end
      if (sck_fall && reading) begin
        if (cnt == dpscd_pkg::BIT_DONE) begin
          o_so_oe_b <= 1'b1;
          reading <= 1'b0;
        end else begin
          o_so <= tx[7];
          tx <= {tx[6:0], 1'b0};
          o_so_oe_b <= 1'b0;
        end
      end
    end
  end

  // Checks
  sequence s_step_edge;
    sck_rise && !cs_rise && state == dpscd_pkg::ST_DATA &&
    op == dpscd_pkg::OP_STEP;
  endsequence

  sequence s_complete_frame_end;
    cs_rise && state == dpscd_pkg::ST_DATA;
  endsequence

  a_step_up_move: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_step_edge ##0 (filt.si && wiper[pot] != dpscd_pkg::POS_MAX) |=>
    wiper[pot] == $past(wiper[pot]) + 8'h01)
    else $error("wiper did not step up");
  a_step_down_move: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_step_edge ##0 (!filt.si && wiper[pot] != dpscd_pkg::POS_MIN) |=>
    wiper[pot] == $past(wiper[pot]) - 8'h01)
    else $error("wiper did not step down");
  a_step_saturate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_step_edge ##0 (filt.si && wiper[pot] == dpscd_pkg::POS_MAX) |=>
    wiper[pot] == dpscd_pkg::POS_MAX)
    else $error("wiper wrapped at top");
  a_addr_reject: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    sck_rise && !cs_rise && state == dpscd_pkg::ST_ID &&
    cnt == dpscd_pkg::BIT_ID_LAST && nbyte[1:0] != filt.addr |=>
    state == dpscd_pkg::ST_SKIP)
    else $error("foreign address accepted");
  a_write_wiper_load: assert property (@(posedge i_clock)
    disable iff (!i_rst_b)
    sck_rise && !cs_rise && state == dpscd_pkg::ST_DATA &&
    op == dpscd_pkg::OP_WR_WIPER && cnt == dpscd_pkg::BIT_DATA_LAST |=>
    wiper[$past(pot)] == $past(nbyte))
    else $error("wiper write lost");
  a_xfr_wiper_copy: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    s_complete_frame_end ##0 op == dpscd_pkg::OP_XFR_TO_WIPER |=>
    wiper[$past(pot)] == $past(stored[{pot, slot}]))
    else $error("stored to wiper copy wrong");
  a_partial_discard: assert property (@(posedge i_clock)
    disable iff (!i_rst_b)
    cs_rise && (state == dpscd_pkg::ST_ID || state == dpscd_pkg::ST_INSTR)
    |=> $stable(o_wiper_pos_0) && $stable(o_wiper_pos_1) && !nv_start)
    else $error("partial frame changed state");
  a_wip_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    nv_start |=> o_wip [*8])
    else $error("busy flag dropped early");
  a_wip_bound: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_wip |-> timer <= 19'(P_NV_WRITE_CYCLES))
    else $error("write cycle overran");
  a_read_drive: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    sck_fall && reading && !cs_rise && cnt != dpscd_pkg::BIT_DONE |=>
    !o_so_oe_b && o_so == $past(tx[7]))
    else $error("read bit not driven");
  a_skip_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state == dpscd_pkg::ST_SKIP |-> o_so_oe_b && !reading)
    else $error("output driven in ignored frame");
endmodule // dpscd_decoder
`default_nettype wire

// ==== sim/dpscd_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Serial bus master: idle clock low, stands still between frames
module dpscd_host (
  input wire logic i_clock,
  output logic o_sck,
  output logic o_cs_b,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_b
);
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_si = 1'b0;
  end

  // Half of the 200 ns serial clock period
  task automatic half();
    repeat (4) @(posedge i_clock);
  endtask

  // One frame, n bits taken MSB first from v; reply gathered when driven
  task automatic frame(input logic [31:0] v, input int n,
      output logic [7:0] rd, output logic drv);
    rd = 8'h00;
    drv = 1'b0;
    @(posedge i_clock);
    o_cs_b <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      o_si <= v[31 - i];
      half();
      o_sck <= 1'b1;
      half();
      // Late in the high phase, since the reply lags the falling edge
      if (i_so_oe_b === 1'b0) begin
        drv = 1'b1;
        rd = {rd[6:0], i_so};
      end
      o_sck <= 1'b0;
    end
    half();
    o_cs_b <= 1'b1;
    o_si <= ~o_si; // Released line shows no stale value
    half();
    half();
  endtask
endmodule // dpscd_host
`default_nettype wire

// ==== sim/dpscd_decoder_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module dpscd_decoder_tb_top;
  localparam int NV = 50;
  localparam logic [3:0] DEV = 4'h6; // Arbitrary value
  logic i_clock, i_rst_b, sck, cs_b, si, a1, a0, so, so_oe_b, nonvolatile_write_active, drv;
  logic [7:0] wp0, wp1, rd, v;
  logic [7:0] mw [2];
  logic [7:0] ms [8];
  logic [3:0] bad [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
  int errors, n_tests;

  dpscd_decoder #(.P_DEVICE_TYPE(DEV), .P_NV_WRITE_CYCLES(NV)) dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sck(sck), .i_cs_b(cs_b),
    .i_si(si), .i_chip_address_bit_one(a1), .i_chip_address_bit_zero(a0),
    .o_so(so), .o_so_oe_b(so_oe_b), .o_wip(nonvolatile_write_active),
    .o_wiper_pos_0(wp0), .o_wiper_pos_1(wp1));
  dpscd_host host_u (.i_clock(i_clock), .o_sck(sck), .o_cs_b(cs_b),
    .o_si(si), .i_so(so), .i_so_oe_b(so_oe_b));

  // 40 MHz system clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // fl flips address bits to make a frame for another chip
  task automatic cmd(input logic [3:0] op, input logic [1:0] sl,
      input logic p, input logic [15:0] d, input int n,
      input logic [1:0] fl);
    host_u.frame({DEV, 2'b00, {a1, a0} ^ fl, op, sl, 1'b0, p, d}, n, rd,
      drv);
  endtask

  task automatic chkw();
    chk("wiper0", wp0, mw[0]);
    chk("wiper1", wp1, mw[1]);
  endtask

  // Busy flag must be up, then drop within the write time
  task automatic nvwait();
    int c;
    c = 0;
    chk("wip_set", nonvolatile_write_active, 1'b1);
    while (nonvolatile_write_active === 1'b1 && c < 2 * NV) begin
      @(posedge i_clock);
      c++;
    end
    chk("wip_len", c <= NV, 1'b1);
  endtask

  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    wrap_up();
  end

  initial begin
    logic [15:0] pat;
    errors = 0;
    n_tests = 0;
    i_rst_b = 1'b0;
    {a1, a0} = 2'b00;
    foreach (mw[i]) mw[i] = 8'h00;
    foreach (ms[i]) ms[i] = 8'h00;
    void'($urandom(97122));
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    {a1, a0} <= 2'($urandom);
    repeat (8) @(posedge i_clock);
    chkw();
    chk("wip_idle", nonvolatile_write_active, 1'b0);
    // Direct reads and writes of every register
    for (int p = 0; p < 2; p++) begin
      v = 8'($urandom);
      cmd(dpscd_pkg::OP_WR_WIPER, 2'b00, p[0], {v, 8'h00}, 24, 2'b00);
      mw[p] = v;
      chkw();
      cmd(dpscd_pkg::OP_RD_WIPER, 2'b00, p[0], 16'h0000, 24, 2'b00);
      chk("rd_wiper", rd, mw[p]);
      for (int s = 0; s < 4; s++) begin
        v = 8'($urandom);
        cmd(dpscd_pkg::OP_WR_STORED, 2'(s), p[0], {v, 8'h00}, 24, 2'b00);
        ms[{p[0], 2'(s)}] = v;
        nvwait();
        cmd(dpscd_pkg::OP_RD_STORED, 2'(s), p[0], 16'h0000, 24, 2'b00);
        chk("rd_stored", rd, ms[{p[0], 2'(s)}]);
      end
    end
    // Single and global copies
    cmd(dpscd_pkg::OP_XFR_TO_WIPER, 2'b10, 1'b1, 16'h0000, 16, 2'b00);
    mw[1] = ms[6];
    chkw();
    cmd(dpscd_pkg::OP_XFR_TO_STORED, 2'b11, 1'b0, 16'h0000, 16, 2'b00);
    ms[3] = mw[0];
    nvwait();
    cmd(dpscd_pkg::OP_RD_STORED, 2'b11, 1'b0, 16'h0000, 24, 2'b00);
    chk("rd_stored", rd, ms[3]);
    cmd(dpscd_pkg::OP_GLB_TO_WIPER, 2'b01, 1'b0, 16'h0000, 16, 2'b00);
    mw[0] = ms[1];
    mw[1] = ms[5];
    chkw();
    v = 8'($urandom);
    cmd(dpscd_pkg::OP_WR_WIPER, 2'b00, 1'b1, {v, 8'h00}, 24, 2'b00);
    mw[1] = v;
    chkw();
    cmd(dpscd_pkg::OP_GLB_TO_STORED, 2'b00, 1'b0, 16'h0000, 16, 2'b00);
    ms[0] = mw[0];
    ms[4] = mw[1];
    nvwait();
    for (int p = 0; p < 2; p++) begin
      cmd(dpscd_pkg::OP_RD_STORED, 2'b00, p[0], 16'h0000, 24, 2'b00);
      chk("rd_glb", rd, ms[{p[0], 2'b00}]);
    end
    // Stepping into both limits, mixed directions in one frame
    for (int p = 0; p < 2; p++) begin
      v = p[0] ? 8'h02 : 8'hfd;
      pat = p[0] ? 16'h00ff : 16'hff00;
      cmd(dpscd_pkg::OP_WR_WIPER, 2'b00, p[0], {v, 8'h00}, 24, 2'b00);
      mw[p] = v;
      cmd(dpscd_pkg::OP_STEP, 2'b00, p[0], pat, 32, 2'b00);
      for (int i = 15; i >= 0; i--) begin
        if (pat[i] && mw[p] != 8'hff) mw[p]++;
        else if (!pat[i] && mw[p] != 8'h00) mw[p]--;
      end
      chkw();
    end
    // Foreign address, cut frames and unknown opcodes change nothing
    cmd(dpscd_pkg::OP_WR_WIPER, 2'b00, 1'b0, 16'h5a00, 24, 2'b01);
    chkw();
    cmd(dpscd_pkg::OP_RD_WIPER, 2'b00, 1'b0, 16'h0000, 24, 2'b10);
    chk("so_foreign", drv, 1'b0);
    cmd(dpscd_pkg::OP_WR_WIPER, 2'b00, 1'b1, 16'ha500, 20, 2'b00);
    chkw();
    cmd(dpscd_pkg::OP_WR_STORED, 2'b01, 1'b0, 16'ha500, 20, 2'b00);
    chk("wip_cut", nonvolatile_write_active, 1'b0);
    foreach (bad[i]) begin
      cmd(bad[i], 2'b00, 1'b0, 16'h0000, 24, 2'b00);
      chk("so_bad", drv, 1'b0);
      chkw();
    end
    wrap_up();
  end
endmodule // dpscd_decoder_tb_top
`default_nettype wire
